/* field_model.sv */
// far-side model: sensors, fault line, input terminals and trace memory
`timescale 1ns/1ps
module field_model (
   input  wire logic   clk_sys,
   output logic        fault_active,
   output logic [127:0] analog_channels,
   output logic [7:0]  digital_channels,
   output logic [1:0]  term_in,
   output logic        trace_data_error,
   output logic        trace_ram_has_data
);
   initial begin
      fault_active = 1'b0;
      analog_channels = '0;
      digital_channels = 8'h00;
      term_in = 2'h0;
      trace_data_error = 1'b0;
      trace_ram_has_data = 1'b0;
   end

   // ****************************************
   // stimulus tasks
   // ****************************************
   // unselected channels move the other way, so a wrong pick shows up
   task automatic drive(input logic [15:0] a, input logic d, input logic f);
      @(posedge clk_sys);
      for (int i = 0; i < 8; i++) begin
         analog_channels[16*i +: 16] <= (i == 2) ? a : 16'h0 - a;
         digital_channels[i] <= (i == 5) ? d : ~d;
      end
      fault_active <= f;
   endtask

   task automatic pins(input logic [1:0] t, input logic r);
      @(posedge clk_sys);
      term_in <= t;
      trace_ram_has_data <= r;
   endtask

   task automatic data_fault();
      @(posedge clk_sys);
      trace_data_error <= 1'b1;
      @(posedge clk_sys);
      trace_data_error <= 1'b0;
   endtask
endmodule

/* tb.sv */
// self-checking bench for the trace trigger and sampling control block
`timescale 1ns/1ps
`include "trace_defs.svh"
module tb
   import trace_pkg::*;
;
   typedef struct packed {
      logic [2:0] src;
      logic [1:0] dir;
      logic [7:0] a0;
      logic [7:0] a1;
      logic [3:0] f;
   } row_s;

   logic         clk_sys = 1'b0;
   logic         reset = 1'b1;
   logic [7:0]   avs_address = 8'h00;
   logic         avs_read = 1'b0;
   logic         avs_write = 1'b0;
   logic [31:0]  avs_writedata = 32'h0;
   logic         sampling_auto_start = 1'b0;
   logic [31:0]  avs_readdata;
   logic         avs_waitrequest;
   logic         fault_active;
   logic [127:0] analog_channels;
   logic [7:0]   digital_channels;
   logic [1:0]   term_in;
   logic         trace_data_error;
   logic         trace_ram_has_data;
   logic         sampling_enable;
   logic         trace_trigger;
   logic         trace_active_output;
   logic [15:0]  status_digits;
   logic [3:0]   status_blank;
   logic         panel_show_status;
   logic [31:0]  rd;
   row_s         rows [12];
   int           mismatches = 0;
   int           n_checks = 0;
   int           hits;

   always #20 clk_sys = ~clk_sys;

   trace_ctrl #(.RETRY_WINDOW_CYC(50)) DUT (
      .clk_sys, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
      .avs_waitrequest, .sampling_auto_start, .fault_active, .analog_channels,
      .digital_channels, .term_in, .trace_data_error, .trace_ram_has_data, .sampling_enable,
      .trace_trigger, .trace_active_output, .status_digits, .status_blank, .panel_show_status);
   field_model plant (.clk_sys, .fault_active, .analog_channels, .digital_channels, .term_in,
      .trace_data_error, .trace_ram_has_data);

   task automatic results();
      if (mismatches == 0 && n_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // held until waitrequest is sampled low at a rising edge, released at that edge
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int i;
      i = 0;
      @(posedge clk_sys);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= ~wr;
      avs_writedata <= d;
      do begin
         @(posedge clk_sys);
         i++;
      end while (avs_waitrequest !== 1'b0 && i < 20);
      rd = avs_readdata;
      if (avs_waitrequest !== 1'b0) begin
         mismatches++;
         results();
      end
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask

   task automatic rdreg(input logic [7:0] a);
      bus(1'b0, a, 32'h0);
   endtask

   task automatic watch(input int n);
      hits = 0;
      repeat (n) begin
         @(negedge clk_sys);
         if (trace_trigger === 1'b1) hits++;
      end
   endtask

   initial begin
      repeat (30000) @(posedge clk_sys);
      mismatches++;
      results();
   end

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      rows = '{'{SRC_FAULT, 2'h0, 8'h00, 8'h00, 4'h3}, '{SRC_ANALOG, 2'h0, 8'h00, 8'h64, 4'h1},
         '{SRC_ANALOG, 2'h2, 8'h64, 8'h00, 4'h1}, '{SRC_ANALOG, 2'h0, 8'h00, 8'h32, 4'h0},
         '{SRC_ANALOG, 2'h0, 8'h00, 8'h00, 4'h6}, '{SRC_DIGITAL, 2'h0, 8'h00, 8'h00, 4'h5},
         '{SRC_DIGITAL, 2'h1, 8'h00, 8'h00, 4'h9}, '{SRC_DIGITAL, 2'h0, 8'h00, 8'h64, 4'h0},
         '{SRC_OR, 2'h0, 8'h00, 8'h00, 4'h5}, '{SRC_OR, 2'h0, 8'h00, 8'h64, 4'h1},
         '{SRC_AND, 2'h0, 8'h00, 8'h00, 4'h4}, '{SRC_AND, 2'h0, 8'h00, 8'h64, 4'h5}};
      repeat (3) @(posedge clk_sys);
      reset <= 1'b0;
      wr(`OFS_MONITOR_SEL, 32'h0000_2600);
      repeat (2) @(negedge clk_sys);
      check(32'(panel_show_status), 32'h1);
      wr(`OFS_MONITOR_SEL, 32'h0000_0026);
      repeat (2) @(negedge clk_sys);
      check(32'(panel_show_status), 32'h1);
      wr(`OFS_MONITOR_SEL, 32'h0026_2500);
      repeat (2) @(negedge clk_sys);
      check(32'(panel_show_status), 32'h1);
      wr(`OFS_MONITOR_SEL, 32'h0027_2527);
      repeat (2) @(negedge clk_sys);
      check(32'(panel_show_status), 32'h0);
      wr(`OFS_TERM_SEL, 32'h0028_2f2e);
      wr(`OFS_TRIG_LEVEL, 32'h41a);
      foreach (rows[k]) begin
         plant.drive({8'h00, rows[k].a0}, rows[k].f[3], 1'b0);
         wr(`OFS_TRIG_CFG, {17'h0, 3'h5, 1'b0, 3'h2, 2'h0, rows[k].dir[0], rows[k].dir[1],
            1'b0, rows[k].src});
         wr(`OFS_COMMAND, 32'h1);
         repeat (4) @(negedge clk_sys);
         check(32'(sampling_enable), 32'h1);
         check(32'(trace_active_output), 32'h1);
         plant.drive({8'h00, rows[k].a1}, rows[k].f[2], rows[k].f[1]);
         watch(12);
         check(32'(hits), {31'h0, rows[k].f[0]});
         wr(`OFS_COMMAND, 32'h3);
         rdreg(`OFS_STATUS);
         check({28'h0, rd[3:0]}, 32'h0);
         if (rows[k].f[0]) check({28'h0, rd[7:4]}, 32'h1);
      end
      // source 7 never fires, so only forcing can raise trace_trigger
      wr(`OFS_TRIG_CFG, 32'h7);
      wr(`OFS_COMMAND, 32'h1);
      wr(`OFS_COMMAND, 32'h0);
      @(negedge clk_sys);
      check(32'(sampling_enable), 32'h1);
      fork wr(`OFS_COMMAND, 32'h2); watch(10); join
      check(32'(hits), 32'h1);
      check(32'(sampling_enable), 32'h0);
      wr(`OFS_COMMAND, 32'h1);
      fork plant.pins(2'h1, 1'b0); watch(10); join
      check(32'(hits), 32'h1);
      plant.pins(2'h0, 1'b0);
      plant.pins(2'h2, 1'b0);
      repeat (6) @(negedge clk_sys);
      check(32'(sampling_enable), 32'h1);
      wr(`OFS_TERM_SEL, 32'h008c_2f2e);
      repeat (3) @(negedge clk_sys);
      check(32'(trace_active_output), 32'h0);
      plant.pins(2'h0, 1'b0);
      repeat (6) @(negedge clk_sys);
      check(32'(sampling_enable), 32'h0);
      check(32'(trace_active_output), 32'h1);
      wr(`OFS_COMMAND, 32'h1);
      plant.data_fault();
      repeat (4) @(negedge clk_sys);
      rdreg(`OFS_STATUS);
      check({28'h0, rd[11:8]}, 32'h1);
      check(32'(sampling_enable), 32'h1);
      plant.data_fault();
      wr(`OFS_COMMAND, 32'h1);
      plant.pins(2'h0, 1'b1);
      repeat (3) @(negedge clk_sys);
      check(32'(sampling_enable), 32'h0);
      rdreg(`OFS_STATUS);
      check({20'h0, rd[19:8]}, 32'h012);
      // second reset with auto start on
      plant.pins(2'h0, 1'b0);
      @(posedge clk_sys);
      reset <= 1'b1;
      sampling_auto_start <= 1'b1;
      repeat (2) @(negedge clk_sys);
      check({28'h0, status_blank}, 32'he);
      repeat (3) @(posedge clk_sys);
      reset <= 1'b0;
      repeat (4) @(negedge clk_sys);
      check(32'(sampling_enable), 32'h1);
      rdreg(`OFS_STATUS);
      check({12'h0, rd[19:0]}, 32'he0001);
      rdreg(`OFS_TRIG_LEVEL);
      check(rd, 32'h3e8);
      rdreg(8'h20);
      check(rd, 32'h0);
      results();
   end
endmodule

/* trace_ctrl.sv */
// trace trigger selection, sampling control, retry and status display
`timescale 1ns/1ps
`include "trace_defs.svh"

module trace_ctrl
   import trace_pkg::*;
#(
   parameter int RETRY_WINDOW_CYC = `RETRY_WINDOW_S * `CLK_HZ
) (
   input  wire logic         clk_sys,
   input  wire logic         reset,
   input  wire logic [7:0]   avs_address,
   input  wire logic         avs_read,
   input  wire logic         avs_write,
   input  wire logic [31:0]  avs_writedata,
   output logic [31:0]       avs_readdata,
   output logic              avs_waitrequest,
   input  wire logic         sampling_auto_start,
   input  wire logic         fault_active,
   input  wire logic [127:0] analog_channels,
   input  wire logic [7:0]   digital_channels,
   input  wire logic [1:0]   term_in,
   input  wire logic         trace_data_error,
   input  wire logic         trace_ram_has_data,
   output logic              sampling_enable,
   output logic              trace_trigger,
   output logic              trace_active_output,
   output logic [15:0]       status_digits,
   output logic [3:0]        status_blank,
   output logic              panel_show_status
);

   // ****************************************
   // registers and bus slave
   // ****************************************
   logic [15:0]  cfg_q;
   logic [10:0]  level_q;
   logic [1:0]   cmd_q;
   logic [23:0]  mon_sel_q;
   logic [23:0]  term_sel_q;
   logic         ack_q;
   logic [31:0]  rdata_q;
   logic         wr_en;
   logic         cmd_wr;
   logic [1:0]   retry_digit_q;
   logic         trig_seen_q;
   trace_state_e state_q;
   trace_state_e state_d;

   // one wait cycle so read data can come from a flop
   assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
   assign wr_en = avs_write & ack_q;
   assign cmd_wr = wr_en && (avs_address == `OFS_COMMAND);

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= (avs_read | avs_write) & ~ack_q;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         cfg_q      <= `RST_TRIG_CFG;
         level_q    <= `RST_TRIG_LEVEL;
         cmd_q      <= CMD_STANDBY;
         mon_sel_q  <= 24'h000000;
         term_sel_q <= 24'h000000;
      end else if (wr_en) begin
         case (avs_address)
            `OFS_TRIG_CFG:    cfg_q <= avs_writedata[15:0];
            `OFS_TRIG_LEVEL:  level_q <= avs_writedata[10:0];
            `OFS_COMMAND:     cmd_q <= avs_writedata[1:0];
            `OFS_MONITOR_SEL: mon_sel_q <= avs_writedata[23:0];
            `OFS_TERM_SEL:    term_sel_q <= avs_writedata[23:0];
            default:          ;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         rdata_q <= 32'h00000000;
      end else if (avs_read & ~ack_q) begin
         case (avs_address)
            `OFS_TRIG_CFG:    rdata_q <= {16'h0000, cfg_q};
            `OFS_TRIG_LEVEL:  rdata_q <= {21'h000000, level_q};
            `OFS_COMMAND:     rdata_q <= {30'h00000000, cmd_q};
            `OFS_STATUS:      rdata_q <= {12'h000, status_blank, status_digits};
            `OFS_MONITOR_SEL: rdata_q <= {8'h00, mon_sel_q};
            `OFS_TERM_SEL:    rdata_q <= {8'h00, term_sel_q};
            default:          rdata_q <= 32'h00000000;
         endcase
      end
   end

   assign avs_readdata = rdata_q;

   // ****************************************
   // pin synchronisers
   // ****************************************
   logic [9:0] pin_s1_q;
   logic [9:0] pin_s2_q;
   logic [9:0] pin_raw;

   assign pin_raw = {term_in, digital_channels};

   genvar gi;
   generate
      for (gi = 0; gi < 10; gi++) begin : g_sync
         always_ff @(posedge clk_sys) begin
            if (reset) begin
               pin_s1_q[gi] <= 1'b0;
               pin_s2_q[gi] <= 1'b0;
            end else begin
               pin_s1_q[gi] <= pin_raw[gi];
               pin_s2_q[gi] <= pin_s1_q[gi];
            end
         end
      end
   endgenerate

   // ****************************************
   // input terminal function routing
   // ****************************************
   logic force_in;
   logic gate_in;
   logic gate_prev_q;

   assign force_in = (term_sel_q[7:0] == `CODE_TRG_IN && pin_s2_q[8]) ||
                     (term_sel_q[15:8] == `CODE_TRG_IN && pin_s2_q[9]);
   assign gate_in = (term_sel_q[7:0] == `CODE_TRC_IN && pin_s2_q[8]) ||
                    (term_sel_q[15:8] == `CODE_TRC_IN && pin_s2_q[9]);

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         gate_prev_q <= 1'b0;
      end else begin
         gate_prev_q <= gate_in;
      end
   end

   // ****************************************
   // trigger conditions
   // ****************************************
   logic signed [15:0] a_sel;
   logic signed [16:0] a_offs;
   logic               a_lvl;
   logic               d_lvl;
   logic               cond;
   logic               cond_prev_q;
   logic               trig_pulse;
   logic [2:0]         src;

   assign src = cfg_q[`CFG_SRC_LSB +: 3];
   assign a_sel = analog_channels[{cfg_q[`CFG_ACH_LSB +: 3], 4'h0} +: 16];
   // percent shifted by the level offset so both compare unsigned-free
   assign a_offs = 17'(a_sel) + `LEVEL_OFFSET;

   always_comb begin
      a_lvl = a_offs > $signed({6'h00, level_q});
      if (cfg_q[`CFG_ADIR_BIT]) begin
         a_lvl = a_offs < $signed({6'h00, level_q});
      end
   end

   assign d_lvl = pin_s2_q[cfg_q[`CFG_DCH_LSB +: 3]] ^ cfg_q[`CFG_DPOL_BIT];

   always_comb begin
      case (src)
         SRC_FAULT:   cond = fault_active;
         SRC_ANALOG:  cond = a_lvl;
         SRC_DIGITAL: cond = d_lvl;
         SRC_OR:      cond = a_lvl | d_lvl;
         SRC_AND:     cond = a_lvl & d_lvl;
         default:     cond = 1'b0;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         cond_prev_q <= 1'b1;
      end else begin
         cond_prev_q <= cond;
      end
   end

   assign trig_pulse = cond & ~cond_prev_q;

   // ****************************************
   // retry window timer
   // ****************************************
   logic [30:0] win_cnt_q;
   logic        win_run_q;
   logic        err_hit;

   assign err_hit = trace_data_error && (state_q == ST_SAMPLE);

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         win_cnt_q <= 31'h00000000;
         win_run_q <= 1'b0;
      end else if (err_hit) begin
         win_cnt_q <= 31'(RETRY_WINDOW_CYC - 1);
         win_run_q <= 1'b1;
      end else if (win_run_q) begin
         win_cnt_q <= win_cnt_q - 31'h00000001;
         win_run_q <= (win_cnt_q != 31'h00000000);
      end
   end

   // ****************************************
   // sampling state machine
   // ****************************************
   logic boot_q;
   logic start_req;
   logic stop_req;
   logic force_req;

   // power-on and reset both land here, so one path covers both
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         boot_q <= 1'b1;
      end else begin
         boot_q <= 1'b0;
      end
   end

   assign start_req = (boot_q && sampling_auto_start) ||
                      (cmd_wr && avs_writedata[1:0] == CMD_START) ||
                      (gate_in && !gate_prev_q);
   assign stop_req = (cmd_wr && avs_writedata[1:0] == CMD_STOP) ||
                     (!gate_in && gate_prev_q);
   assign force_req = (cmd_wr && avs_writedata[1:0] == CMD_FORCE) || force_in;

   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_IDLE, ST_DONE: begin
            if (start_req && retry_digit_q != 2'h2) begin
               state_d = ST_SAMPLE;
            end
         end
         ST_SAMPLE: begin
            if (err_hit) begin
               state_d = win_run_q ? ST_IDLE : ST_RETRY;
            end else if (force_req || trig_pulse) begin
               state_d = ST_DONE;
            end else if (stop_req) begin
               state_d = ST_IDLE;
            end
         end
         ST_RETRY: state_d = ST_SAMPLE;
         default:  state_d = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         state_q <= ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         trace_trigger <= 1'b0;
      end else begin
         trace_trigger <= (state_q == ST_SAMPLE) && !err_hit && (force_req || trig_pulse);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         trig_seen_q <= 1'b0;
      end else if (state_q == ST_SAMPLE && !err_hit && (force_req || trig_pulse)) begin
         trig_seen_q <= 1'b1;
      end else if (state_q != ST_SAMPLE && state_d == ST_SAMPLE) begin
         trig_seen_q <= 1'b0;
      end
   end

   // excess sticks until reset so a flaky recorder stays visible
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         retry_digit_q <= 2'h0;
      end else if (err_hit) begin
         retry_digit_q <= win_run_q ? 2'h2 : 2'h1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         sampling_enable <= 1'b0;
      end else begin
         sampling_enable <= (state_d == ST_SAMPLE);
      end
   end

   // ****************************************
   // status display and output terminal
   // ****************************************
   logic active;
   logic tr_out_d;

   assign active = (state_q == ST_SAMPLE);

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         status_digits <= 16'h0000;
      end else begin
         status_digits <= {3'h0, trace_ram_has_data, 2'h0, retry_digit_q,
                           3'h0, trig_seen_q, 3'h0, active};
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         status_blank <= 4'he;
      end else begin
         status_blank[3] <= !trace_ram_has_data;
         status_blank[2] <= !trace_ram_has_data && retry_digit_q == 2'h0;
         status_blank[1] <= !trace_ram_has_data && retry_digit_q == 2'h0 && !trig_seen_q;
         status_blank[0] <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         panel_show_status <= 1'b0;
      end else begin
         panel_show_status <= mon_sel_q[7:0] == `CODE_MON_STATUS ||
                              mon_sel_q[15:8] == `CODE_MON_STATUS ||
                              mon_sel_q[23:16] == `CODE_MON_STATUS;
      end
   end

   always_comb begin
      case (term_sel_q[23:16])
         `CODE_OUT_POS: tr_out_d = active;
         `CODE_OUT_NEG: tr_out_d = !active;
         default:       tr_out_d = 1'b0;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         trace_active_output <= 1'b0;
      end else begin
         trace_active_output <= tr_out_d;
      end
   end

endmodule

/* trace_ctrl_props.sv */
// port-level assertions for the trace trigger and sampling control block
`timescale 1ns/1ps
module trace_ctrl_props #(
   parameter int RETRY_WINDOW_CYC = 50
) (
   input wire logic        clk_sys,
   input wire logic        reset,
   input wire logic        sampling_auto_start,
   input wire logic        trace_data_error,
   input wire logic        sampling_enable,
   input wire logic        trace_trigger,
   input wire logic [15:0] status_digits,
   input wire logic [3:0]  status_blank
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (reset);

   // ****************************************
   // assertions
   // ****************************************
   AST_TRIG_ONE: assert property (trace_trigger |=> !trace_trigger)
      else $error("trigger pulse wider than one cycle");
   AST_TRIG_SAMPLING: assert property (trace_trigger |-> $past(sampling_enable))
      else $error("trigger seen outside sampling");
   AST_TRIG_STOPS: assert property (trace_trigger |=> !sampling_enable)
      else $error("sampling kept running after trigger");
   AST_TRIG_DIGIT: assert property (trace_trigger |-> ##[0:2] status_digits[7:4] == 4'h1)
      else $error("trigger digit not set");
   AST_DIGITS: assert property (status_digits[3:0] <= 4'h1 && status_digits[7:4] <= 4'h1
      && status_digits[11:8] <= 4'h2 && status_digits[15:12] <= 4'h1)
      else $error("status digit out of range");
   // blank follows digits once they settle
   AST_BLANK: assert property ($stable(status_digits) |-> status_blank ==
      {status_digits[15:12] == 4'h0, status_digits[15:8] == 8'h0,
       status_digits[15:4] == 12'h0, 1'b0})
      else $error("leading zero blanking wrong");
   AST_ACTIVE: assert property (sampling_enable ##1 sampling_enable |->
      status_digits[3:0] == 4'h1)
      else $error("active digit not set while sampling");
   AST_EXCESS: assert property (status_digits[11:8] == 4'h2 |=>
      status_digits[11:8] == 4'h2 && !sampling_enable)
      else $error("retry excess did not hold sampling off");
   AST_RETRY: assert property (trace_data_error && sampling_enable &&
      status_digits[11:8] == 4'h0 |-> ##[1:3] status_digits[11:8] == 4'h1 ##[0:3] sampling_enable)
      else $error("first data error did not retry");
   AST_AUTO: assert property ($fell(reset) && sampling_auto_start |-> ##[1:3] sampling_enable)
      else $error("auto start did not begin sampling");
endmodule

bind trace_ctrl trace_ctrl_props #(.RETRY_WINDOW_CYC(RETRY_WINDOW_CYC)) u_props (
   .clk_sys, .reset, .sampling_auto_start, .trace_data_error, .sampling_enable,
   .trace_trigger, .status_digits, .status_blank);

/* trace_defs.svh */
// constants for the trace trigger and sampling control block
// Function
// - source select 0 starts tracing when the drive enters a fault state.
// - source select 1 starts tracing on the analog trigger condition only.
// - source select 2 starts tracing on the digital trigger condition only.
// - source select 3 starts tracing when analog or digital condition is met.
// - source select 4 starts tracing when analog and digital conditions both hold.
// - analog direction 0 triggers when the value rises above the level.
// - analog direction 1 triggers when the value drops below the level.
// - digital polarity 0 triggers when the selected signal switches on.
// - digital polarity 1 triggers when the selected signal switches off.
// - command 0 is standby, 1 starts sampling, 3 stops sampling.
// - command 2 is a forced trigger: sampling stops, trace taken.
// - auto-start 1 begins sampling after power-on and after reset.
// - forced-trigger input on applies a forced trigger like command 2.
// - sampling gate input on starts sampling, off stops it.
// - a trace data error stops then restarts sampling and records a retry.
// - a second error within one minute stops sampling and flags retry excess.
// - status is four decimal digits: operation, trigger, retry, RAM state.
// - digit 1 active, trigger, retried, data present; retry digit 2 excess.
// - zero digits left of the highest non-zero digit are blanked.
// - status shown when monitor code 38 is on main or auxiliary slot. The code also shows it when code 38 is on the third slot, mon_sel_q[23:16].
// - trace-active output driven by output code 40 true, 140 inverted.
`ifndef TRACE_DEFS_SVH
`define TRACE_DEFS_SVH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define OFS_TRIG_CFG     8'h00
`define OFS_TRIG_LEVEL   8'h04
`define OFS_COMMAND      8'h08
`define OFS_STATUS       8'h0c
`define OFS_MONITOR_SEL  8'h10
`define OFS_TERM_SEL     8'h14

// ****************************************
// field positions
// ****************************************
`define CFG_SRC_LSB      0
`define CFG_ADIR_BIT     4
`define CFG_DPOL_BIT     5
`define CFG_ACH_LSB      8
`define CFG_DCH_LSB      12

// ****************************************
// reset values and codes
// ****************************************
`define RST_TRIG_CFG     16'h0000
`define RST_TRIG_LEVEL   11'h3e8
`define LEVEL_OFFSET     17'sh003e8
`define CODE_TRG_IN      8'h2e
`define CODE_TRC_IN      8'h2f
`define CODE_MON_STATUS  8'h26
`define CODE_OUT_POS     8'h28
`define CODE_OUT_NEG     8'h8c

// ****************************************
// timing
// ****************************************
`define CLK_HZ           25000000
`define RETRY_WINDOW_S   60

`endif

/* trace_pkg.sv */
// types for the trace trigger and sampling control block
package trace_pkg;
   typedef enum logic [3:0] {
      ST_IDLE   = 4'b0001,
      ST_SAMPLE = 4'b0010,
      ST_RETRY  = 4'b0100,
      ST_DONE   = 4'b1000
   } trace_state_e;

   typedef enum logic [1:0] {
      CMD_STANDBY = 2'h0,
      CMD_START   = 2'h1,
      CMD_FORCE   = 2'h2,
      CMD_STOP    = 2'h3
   } trace_cmd_e;

   typedef enum logic [2:0] {
      SRC_FAULT   = 3'h0,
      SRC_ANALOG  = 3'h1,
      SRC_DIGITAL = 3'h2,
      SRC_OR      = 3'h3,
      SRC_AND     = 3'h4
   } trig_src_e;
endpackage
